// File: sas_analog_model.sv
// Analog mux and trigger sources facing the sequencer.
// Assumes the bench commands every trigger event through i_fire.
`timescale 1ns/1ps
module sas_analog_model
  import sas_pkg::*;
(
  // Clock
  input wire logic i_clk_sys,
  // Converter side
  input wire logic [sas_pkg::CH_W-1:0] i_channel_select,
  input wire logic i_converting,
  output logic [sas_pkg::RES_W-1:0] o_conv_result,
  // Trigger sources
  input wire logic [3:0] i_fire,
  output sas_pkg::sas_trig_type o_trig,
  output logic o_external_irq_pin,
  output logic o_rc_osc
);
  logic [5:0] pin_r = 6'h00;
  logic [9:0] junk_r = 10'h000;
  logic conv_d_r = 1'b0;
  logic rc_r = 1'b0;
  sas_trig_type trig_r = '0;
  always @(posedge i_clk_sys) begin
    pin_r <= {pin_r[4:0], i_fire[0]};
    trig_r <= {i_fire[1], i_fire[2], i_fire[3]};
    junk_r <= junk_r + 10'h133;
    conv_d_r <= i_converting;
    rc_r <= ~rc_r;
  end
  // Moving pattern outside a conversion, so a late sample cannot pass
  assign o_conv_result = (i_converting || conv_d_r) ?
    {i_channel_select, i_channel_select ^ 5'h0a} : junk_r;
  assign o_trig = trig_r;
  assign o_external_irq_pin = |pin_r;
  assign o_rc_osc = rc_r;
endmodule : sas_analog_model

// File: sas_pkg.sv
// Constants and carrier types for the SAR converter sequencer.
// Assumes a 16-bit register port with word addresses.
package sas_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;
  localparam int RES_W = 10;
  localparam int CH_W = 5;
  localparam int PTR_W = 5;
  localparam int BUF_WORDS = 32;
  // Register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CON1 = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_CON2 = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_CON3 = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_INSEL = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_SCAN = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_BUF_BASE = 6'h20;
  // Writable bits of each register
  localparam logic [DATA_W-1:0] CON1_WMASK = 16'ha3e6;
  localparam logic [DATA_W-1:0] CON2_WMASK = 16'he47f;
  localparam logic [DATA_W-1:0] CON3_WMASK = 16'h9fff;
  localparam logic [DATA_W-1:0] INSEL_WMASK = 16'h1f1f;
  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  // Field positions
  localparam int BIT_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int OUTPUT_FORMAT_LSB = 8;
  localparam int SRC_LSB = 5;
  localparam int BIT_AUTO_SAMPLE_START = 2;
  localparam int BIT_SAMPLE_ENABLE = 1;
  localparam int BIT_DONE = 0;
  localparam int REFERENCE_CONFIG_LSB = 13;
  localparam int BIT_SCAN = 10;
  localparam int BIT_FILL = 7;
  localparam int RATE_LSB = 2;
  localparam int BIT_BUFFER_MODE = 1;
  localparam int BIT_ALTERNATE_INPUT = 0;
  localparam int BIT_CLKSRC = 15;
  localparam int AUTO_SAMPLE_TIME_LSB = 8;
  localparam int CONV_CLOCK_SELECT_LSB = 0;
  localparam int INSEL_B_LSB = 8;
  localparam int HALF_LSB = 4;
  // Conversion length in conversion clock periods
  localparam logic [3:0] CONV_TADS = 4'hc;
  // Trigger source codes
  localparam logic [2:0] SRC_MANUAL = 3'h0;
  localparam logic [2:0] SRC_EXT_PIN = 3'h1;
  localparam logic [2:0] SRC_TIMER_THREE_COMPARE = 3'h2;
  localparam logic [2:0] SRC_TIMER_FIVE_COMPARE = 3'h4;
  localparam logic [2:0] SRC_CHARGE = 3'h6;
  localparam logic [2:0] SRC_AUTO = 3'h7;
  // Output format codes
  localparam logic [1:0] OUTPUT_FORMAT_INT = 2'h0;
  localparam logic [1:0] OUTPUT_FORMAT_SINT = 2'h1;
  localparam logic [1:0] OUTPUT_FORMAT_FRAC = 2'h2;
  localparam logic [1:0] OUTPUT_FORMAT_SFRAC = 2'h3;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } sas_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sas_bus_req_type;

  typedef struct packed {
    logic timer_three_compare;
    logic timer_five_compare;
    logic charge_measure_unit;
  } sas_trig_type;

  typedef struct packed {
    logic vref_pos_ext;
    logic vref_neg_ext;
  } sas_ref_type;
endpackage : sas_pkg

// File: sas_sequencer.sv
// Control and sequencing logic of a 10-bit SAR converter.
// Assumes the analog core presents a settled result on i_conv_result when
// the conversion period ends, and that timer and charge events are
// one-cycle pulses on i_clk_sys.
`timescale 1ns/1ps
module sas_sequencer
  import sas_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Register port
  input wire sas_pkg::sas_bus_req_type i_bus,
  output logic [sas_pkg::DATA_W-1:0] o_rdata,
  // Device state and trigger sources
  input wire logic i_device_idle,
  input wire logic i_external_irq_pin,
  input wire logic i_rc_osc,
  input wire sas_pkg::sas_trig_type i_trig,
  // Analog core
  input wire logic [sas_pkg::RES_W-1:0] i_conv_result,
  output logic [sas_pkg::CH_W-1:0] o_channel_select,
  output sas_pkg::sas_ref_type o_ref,
  output logic o_sampling,
  output logic o_converting,
  output logic o_converter_irq_flag
);
  import sas_pkg::*;

  function automatic logic [DATA_W-1:0] fmt(input logic [RES_W-1:0] res,
                                            input logic [1:0] output_format);
    logic [DATA_W-1:0] val;
    val = '0;
    unique case (output_format)
      OUTPUT_FORMAT_INT: val = {{(DATA_W-RES_W){1'b0}}, res};
      OUTPUT_FORMAT_SINT: val = {{(DATA_W-RES_W){res[RES_W-1]}}, res};
      OUTPUT_FORMAT_FRAC: val = {res, {(DATA_W-RES_W){1'b0}}};
      OUTPUT_FORMAT_SFRAC: val = {res, {(DATA_W-RES_W){1'b0}}};
    endcase
    return val;
  endfunction : fmt

  // Next set scan bit after cur, wrapping; cur when none is set
  function automatic logic [CH_W-1:0] next_scan(input logic [DATA_W-1:0] m,
                                                input logic [CH_W-1:0] cur);
    logic [CH_W-1:0] pick;
    logic found;
    logic [CH_W-1:0] idx;
    pick = cur;
    found = 1'b0;
    idx = '0;
    for (int k = 1; k <= DATA_W; k++) begin
      idx = CH_W'((32'(cur) + k) % DATA_W);
      if (!found && m[idx[3:0]]) begin
        pick = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction : next_scan

  // Registers
  logic [DATA_W-1:0] con1_r, con2_r, con3_r, insel_r, scan_r;
  logic sample_enable_r, done_r, fill_r;
  logic [DATA_W-1:0] buf_r [BUF_WORDS];
  logic [DATA_W-1:0] rdata_r;
  sas_state_type state_r, state_nxt;

  // Field views
  wire logic enable = con1_r[BIT_ENABLE];
  wire logic idle_stop = con1_r[BIT_IDLE_STOP];
  wire logic [1:0] output_format = con1_r[OUTPUT_FORMAT_LSB +: 2];
  wire logic [2:0] src = con1_r[SRC_LSB +: 3];
  wire logic auto_sample_start = con1_r[BIT_AUTO_SAMPLE_START];
  wire logic [2:0] reference_config = con2_r[REFERENCE_CONFIG_LSB +: 3];
  wire logic scan_en = con2_r[BIT_SCAN];
  wire logic [4:0] rate = con2_r[RATE_LSB +: 5];
  wire logic buffer_mode = con2_r[BIT_BUFFER_MODE];
  wire logic alternate_input = con2_r[BIT_ALTERNATE_INPUT];
  wire logic clksrc = con3_r[BIT_CLKSRC];
  wire logic [4:0] auto_sample_time = con3_r[AUTO_SAMPLE_TIME_LSB +: 5];
  wire logic [7:0] conv_clock_select = con3_r[CONV_CLOCK_SELECT_LSB +: 8];

  // Bus decode
  wire logic wr_con1 = i_bus.wr && i_bus.addr == ADDR_CON1;
  wire logic wr_con2 = i_bus.wr && i_bus.addr == ADDR_CON2;
  wire logic wr_con3 = i_bus.wr && i_bus.addr == ADDR_CON3;
  wire logic wr_insel = i_bus.wr && i_bus.addr == ADDR_INSEL;
  wire logic wr_scan = i_bus.wr && i_bus.addr == ADDR_SCAN;
  wire logic rd_buf = i_bus.addr[ADDR_W-1];

  // Halted when off or stopped in Idle
  wire logic run = enable && !(idle_stop && i_device_idle);

  // Pin and RC oscillator synchronisers
  logic [1:0] pin_sync_r, rc_sync_r;
  logic pin_old_r, rc_old_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      pin_sync_r <= '0;
      rc_sync_r <= '0;
      pin_old_r <= 1'b0;
      rc_old_r <= 1'b0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], i_external_irq_pin};
      rc_sync_r <= {rc_sync_r[0], i_rc_osc};
      pin_old_r <= pin_sync_r[1];
      rc_old_r <= rc_sync_r[1];
    end
  end
  wire logic pin_edge = pin_sync_r[1] && !pin_old_r;
  wire logic rc_edge = rc_sync_r[1] && !rc_old_r;

  // Conversion clock: one tick per period
  // Ticks stop while halted, so a frozen conversion cannot run on and
  // store a result or raise the interrupt behind the halt.
  logic [7:0] div_r;
  wire logic div_end = div_r == conv_clock_select;
  wire logic conv_clock_period = run && (clksrc ? rc_edge : div_end);
  // Divider restarts while halted so the first period after it is whole
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !run || div_end)
      div_r <= '0;
    else
      div_r <= div_r + 8'h01;
  end

  // Sequencer
  logic [4:0] auto_sample_time_cnt_r;
  logic [3:0] conv_cnt_r;
  logic [4:0] seq_r;
  logic alt_r;
  logic [CH_W-1:0] scan_ch_r;

  // Reserved trigger codes match no qualifier and never convert
  wire logic ext_trig = (src == SRC_EXT_PIN && pin_edge)
    || (src == SRC_TIMER_THREE_COMPARE && i_trig.timer_three_compare)
    || (src == SRC_TIMER_FIVE_COMPARE && i_trig.timer_five_compare)
    || (src == SRC_CHARGE && i_trig.charge_measure_unit);
  wire logic auto_trig = src == SRC_AUTO && auto_sample_time_cnt_r >= auto_sample_time;
  wire logic manual_trig = src == SRC_MANUAL && !sample_enable_r;
  wire logic trig = ext_trig || auto_trig || manual_trig;
  // Length counted in conversion clock ticks, not system cycles
  wire logic conv_end = conv_clock_period && conv_cnt_r == CONV_TADS - 4'h1;
  wire logic finish = state_r == ST_CONVERT && conv_end;
  wire logic seq_wrap = seq_r == rate;
  wire logic [PTR_W-1:0] wr_ptr = buffer_mode
    ? {fill_r, seq_r[HALF_LSB-1:0]} : seq_r;
  wire logic use_b = alternate_input && alt_r;
  wire logic [CH_W-1:0] ch_a = scan_en
    ? scan_ch_r : insel_r[CH_W-1:0];
  wire logic [CH_W-1:0] ch_sel = use_b
    ? insel_r[INSEL_B_LSB +: CH_W] : ch_a;
  // Lowest selected scan channel; a period whose last sample is not a B sample restarts there
  wire logic [CH_W-1:0] scan_first = next_scan(scan_r, CH_W'(DATA_W - 1));

  always_comb begin
    state_nxt = state_r;
    if (!run) begin
      state_nxt = enable ? state_r : ST_HOLD;
    end else begin
      unique case (state_r)
        ST_HOLD: if (sample_enable_r) state_nxt = ST_SAMPLE;
        ST_SAMPLE: begin
          if (trig)
            state_nxt = ST_CONVERT;
          else if (!sample_enable_r)
            state_nxt = ST_HOLD;
        end
        ST_CONVERT: if (conv_end) state_nxt = auto_sample_start ? ST_SAMPLE : ST_HOLD;
        default: state_nxt = ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_r <= ST_HOLD;
      auto_sample_time_cnt_r <= '0;
      conv_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      // Sample counter saturates so a long sampling time cannot wrap it
      if (state_r != ST_SAMPLE)
        auto_sample_time_cnt_r <= '0;
      else if (conv_clock_period && auto_sample_time_cnt_r != auto_sample_time)
        auto_sample_time_cnt_r <= auto_sample_time_cnt_r + 5'h01;
      if (state_r != ST_CONVERT)
        conv_cnt_r <= '0;
      else if (conv_clock_period)
        conv_cnt_r <= conv_cnt_r + 4'h1;
    end
  end

  // Status bits: hardware events win over the software write
  wire logic start_conv = run && state_r == ST_SAMPLE && trig;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !enable) begin
      sample_enable_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (finish && auto_sample_start)
        sample_enable_r <= 1'b1;
      else if (start_conv)
        sample_enable_r <= 1'b0;
      else if (wr_con1)
        sample_enable_r <= i_bus.wdata[BIT_SAMPLE_ENABLE];
      if (finish)
        done_r <= 1'b1;
      else if (start_conv)
        done_r <= 1'b0;
    end
  end

  // Sequence counting, mux stepping and buffer half
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !enable) begin
      seq_r <= '0;
      alt_r <= 1'b0;
      fill_r <= 1'b0;
    end else if (finish) begin
      seq_r <= seq_wrap ? 5'h00 : seq_r + 5'h01;
      alt_r <= alternate_input && !alt_r;
      if (seq_wrap && buffer_mode)
        fill_r <= !fill_r;
    end
  end

  // Scan pointer parks on the first selected channel while disabled, so
  // the first scanned sample never lands on an unselected input.
  // B samples leave it where it is.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset)
      scan_ch_r <= '0;
    else if (!enable)
      scan_ch_r <= scan_first;
    else if (finish && !use_b)
      scan_ch_r <= seq_wrap
        ? scan_first : next_scan(scan_r, scan_ch_r);
  end

  // Result store; disabling wipes it
  always_ff @(posedge i_clk_sys) begin
    for (int i = 0; i < BUF_WORDS; i++) begin
      if (i_reset || !enable)
        buf_r[i] <= '0;
      else if (finish && wr_ptr == PTR_W'(i))
        buf_r[i] <= fmt(i_conv_result, output_format);
    end
  end

  // Software registers
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      con1_r <= REG_RESET;
      con2_r <= REG_RESET;
      con3_r <= REG_RESET;
      insel_r <= REG_RESET;
      scan_r <= REG_RESET;
    end else begin
      if (wr_con1)
        con1_r <= i_bus.wdata & CON1_WMASK;
      if (wr_con2)
        con2_r <= i_bus.wdata & CON2_WMASK;
      if (wr_con3)
        con3_r <= i_bus.wdata & CON3_WMASK;
      if (wr_insel)
        insel_r <= i_bus.wdata & INSEL_WMASK;
      if (wr_scan)
        scan_r <= i_bus.wdata;
    end
  end

  // Read path; unmapped addresses read zero
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (rd_buf)
      rd_mux = buf_r[i_bus.addr[PTR_W-1:0]];
    else if (i_bus.addr == ADDR_CON1) begin
      rd_mux = con1_r;
      // Status bits come from their own flops, not the stored copy
      rd_mux[BIT_SAMPLE_ENABLE] = sample_enable_r;
      rd_mux[BIT_DONE] = done_r;
    end else if (i_bus.addr == ADDR_CON2) begin
      rd_mux = con2_r;
      rd_mux[BIT_FILL] = fill_r;
    end else if (i_bus.addr == ADDR_CON3)
      rd_mux = con3_r;
    else if (i_bus.addr == ADDR_INSEL)
      rd_mux = insel_r;
    else if (i_bus.addr == ADDR_SCAN)
      rd_mux = scan_r;
  end

  // Outputs, all registered
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata_r <= '0;
      o_channel_select <= '0;
      o_ref <= '0;
      o_sampling <= 1'b0;
      o_converting <= 1'b0;
      o_converter_irq_flag <= 1'b0;
    end else begin
      rdata_r <= i_bus.rd ? rd_mux : '0;
      o_channel_select <= ch_sel;
      o_ref.vref_pos_ext <= !reference_config[2] && reference_config[0];
      o_ref.vref_neg_ext <= !reference_config[2] && reference_config[1];
      o_sampling <= state_nxt == ST_SAMPLE && run;
      o_converting <= state_nxt == ST_CONVERT && run;
      // Pulses one cycle after the last conversion of a period
      o_converter_irq_flag <= finish && seq_wrap;
    end
  end
  assign o_rdata = rdata_r;
endmodule : sas_sequencer

// File: sas_sequencer_chk.sv
// Pin-level properties of the converter sequencer.
// Bound to every sas_sequencer; sees only its ports.
`timescale 1ns/1ps
module sas_sequencer_chk
  import sas_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Device state
  input wire logic i_device_idle,
  // Register port
  input wire sas_pkg::sas_bus_req_type i_bus,
  input wire logic [sas_pkg::DATA_W-1:0] o_rdata,
  // Analog core
  input wire logic [sas_pkg::CH_W-1:0] o_channel_select,
  input wire sas_pkg::sas_ref_type o_ref,
  input wire logic o_sampling,
  input wire logic o_converting,
  input wire logic o_converter_irq_flag
);
  import sas_pkg::*;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire con2_wr = i_bus.wr && i_bus.addr == ADDR_CON2;
  logic [1:0] ref_exp_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset)
      ref_exp_r <= 2'h0;
    else if (con2_wr)
      ref_exp_r <= {~i_bus.wdata[15] & i_bus.wdata[13],
                    ~i_bus.wdata[15] & i_bus.wdata[14]};
  end
  irq_one_cycle_a:
    assert property (o_converter_irq_flag |=> !o_converter_irq_flag)
    else $error("irq flag stood longer than one cycle");
  irq_after_conv_a:
    assert property (o_converter_irq_flag |-> $past(o_converting) ||
      $past(o_converting, 2) || $past(o_converting, 3))
    else $error("irq flag without a finished conversion");
  sample_hold_excl_a:
    assert property (!(o_sampling && o_converting))
    else $error("sampling and converting at once");
  conv_min_len_a:
    assert property ($rose(o_converting) && $past(o_sampling) |->
      (o_converting || i_device_idle || $past(i_device_idle)) [*8] ##1
      (o_converting || i_device_idle || $past(i_device_idle)) [*4])
    else $error("conversion shorter than twelve cycles");
  conv_after_sample_enable_a:
    assert property ($rose(o_converting) && !$past(i_device_idle, 2) |->
      $past(o_sampling))
    else $error("conversion started without sampling");
  chan_hold_a:
    assert property ($rose(o_converting) |=> $stable(o_channel_select) [*4])
    else $error("channel changed during conversion");
  con1_spare_zero_a:
    assert property (i_bus.rd && i_bus.addr == ADDR_CON1 |=>
      (o_rdata & ~16'ha3e7) == 16'h0000)
    else $error("unused control bits read as one");
  ref_select_a:
    assert property ($past(con2_wr, 2) && !$past(con2_wr) |->
      o_ref == ref_exp_r)
    else $error("reference selects disagree with config");
  cover property (o_converter_irq_flag);
  cover property ($rose(o_converting));
  cover property (con2_wr);
endmodule : sas_sequencer_chk

bind sas_sequencer sas_sequencer_chk u_chk (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_device_idle(i_device_idle), .i_bus(i_bus),
  .o_rdata(o_rdata),
  .o_channel_select(o_channel_select), .o_ref(o_ref),
  .o_sampling(o_sampling), .o_converting(o_converting),
  .o_converter_irq_flag(o_converter_irq_flag));

// File: sas_sequencer_test.sv
// Self-checking bench for the converter sequencer.
// Assumes the analog model answers from the selected channel.
`timescale 1ns/1ps
module sas_sequencer_test;
  import sas_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  sas_bus_req_type bus = '0;
  logic idle = 1'b0;
  logic [3:0] fire = 4'h0;
  logic [15:0] rdata;
  logic [4:0] chan;
  sas_ref_type vref;
  sas_trig_type trig;
  logic sample_enable, conv, irq, pin, rc, conv_d = 1'b0;
  logic [9:0] res;
  logic [31:0] seed = 32'h7;
  int miscompares = 0;
  int n_checks = 0;
  int n_conv = 0;
  int cycles = 0;
  int n_irq = 0;
  logic [2:0] srcs [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
  logic [5:0] addrs [5] = '{ADDR_CON2, ADDR_CON3, ADDR_INSEL, ADDR_SCAN, 6'h05};
  logic [15:0] masks [5] = '{16'he47f, 16'h9fff, 16'h1f1f, 16'hffff, 16'h0};

  sas_sequencer dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_bus(bus),
    .o_rdata(rdata), .i_device_idle(idle), .i_external_irq_pin(pin),
    .i_rc_osc(rc), .i_trig(trig), .i_conv_result(res),
    .o_channel_select(chan), .o_ref(vref), .o_sampling(sample_enable),
    .o_converting(conv), .o_converter_irq_flag(irq));
  sas_analog_model u_model (.i_clk_sys(i_clk_sys), .i_channel_select(chan),
    .i_converting(conv), .o_conv_result(res), .i_fire(fire), .o_trig(trig),
    .o_external_irq_pin(pin), .o_rc_osc(rc));

  always #20 i_clk_sys = ~i_clk_sys;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [15:0] fmt(input logic [4:0] c, input logic [1:0] f);
    logic [9:0] r;
    r = {c, c ^ 5'h0a};
    if (f == OUTPUT_FORMAT_INT) return {6'h00, r};
    if (f == OUTPUT_FORMAT_SINT) return {{6{r[9]}}, r};
    return {r, 6'h00};
  endfunction : fmt

  function automatic logic [4:0] scan_ch(input logic [15:0] m, input int k);
    int n = 0;
    for (int c = 0; c < 64; c++) begin
      if (m[c % 16]) begin
        if (n == k) return 5'(c % 16);
        n++;
      end
    end
    return 5'h00;
  endfunction : scan_ch

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdc

  task automatic pulse(input logic [3:0] m);
    @(posedge i_clk_sys);
    fire <= m;
    @(posedge i_clk_sys);
    fire <= 4'h0;
  endtask : pulse

  // Polls the done bit; a read burns two cycles
  task automatic wait_done();
    for (int i = 0; i < 400; i++) begin
      @(posedge i_clk_sys);
      bus <= '{addr: ADDR_CON1, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      bus.rd <= 1'b0;
      #1;
      if (rdata[BIT_DONE] === 1'b1) return;
    end
    chk(16'h0000, 16'h0001);
  endtask : wait_done

  task automatic wait_irq();
    for (int i = 0; i < 4000; i++) begin
      @(posedge i_clk_sys);
      #1;
      if (irq === 1'b1) return;
    end
    chk(16'h0000, 16'h0001);
  endtask : wait_irq

  always @(posedge i_clk_sys) begin
    conv_d <= conv;
    if (conv_d && !conv) n_conv++;
    if (irq === 1'b1) n_irq++;
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] r;
    logic [4:0] ch, ca, cb;
    logic [15:0] base, m;
    int n0, i0;
    repeat (20) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    rdc(ADDR_CON1, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      rdc(addrs[i], 16'h0000);
      wr(addrs[i], 16'hffff);
      rdc(addrs[i], masks[i]);
      wr(addrs[i], 16'h0000);
    end
    $display("test registers finished");
    foreach (srcs[k]) begin
      r = xs();
      ch = {1'b0, r[3:0]};
      base = 16'h8000 | {6'h00, 2'(k), srcs[k], 5'h00};
      wr(ADDR_INSEL, {11'h000, ch});
      wr(ADDR_CON3, {k == 5, 2'h0, 5'h01, 5'h00, r[6:4]});
      wr(ADDR_CON1, base);
      wr(ADDR_CON1, base | 16'h0002);
      if (srcs[k] != SRC_AUTO) rdc(ADDR_CON1, base | 16'h0002);
      if (srcs[k] == SRC_MANUAL) wr(ADDR_CON1, base);
      else if (srcs[k] != SRC_AUTO) pulse(4'h1 << (srcs[k] >> 1));
      wait_done();
      rdc(ADDR_BUF_BASE, fmt(ch, 2'(k)));
      wr(ADDR_CON1, 16'h0000);
      rdc(ADDR_BUF_BASE, 16'h0000);
    end
    for (int i = 0; i < 2; i++) begin
      base = i ? 16'h80a0 : 16'h8060;
      wr(ADDR_CON1, base);
      wr(ADDR_CON1, base | 16'h0002);
      pulse(4'hf);
      repeat (40) @(posedge i_clk_sys);
      rdc(ADDR_CON1, base | 16'h0002);
      wr(ADDR_CON1, 16'h0000);
    end
    $display("test triggers finished");
    r = xs();
    ca = {1'b0, r[3:0]};
    cb = {1'b0, r[7:4]};
    wr(ADDR_INSEL, {3'h0, cb, 3'h0, ca});
    wr(ADDR_CON2, 16'h000f);
    wr(ADDR_CON3, 16'h1f00);
    wr(ADDR_CON1, 16'ha0e4);
    wr(ADDR_CON1, 16'ha0e6);
    for (int p = 0; p < 2; p++) begin
      wait_irq();
      if (p == 1) chk(16'(n_conv - n0), 16'h0004);
      n0 = n_conv;
      rdc(ADDR_CON2, {8'h00, p == 0, 7'h0f});
      for (int j = 0; j < 4; j++)
        rdc(ADDR_BUF_BASE + 6'(16 * p + j), fmt(j[0] ? cb : ca, OUTPUT_FORMAT_INT));
    end
    @(posedge i_clk_sys);
    idle <= 1'b1;
    repeat (5) @(posedge i_clk_sys);
    n0 = n_conv;
    i0 = n_irq;
    repeat (200) @(posedge i_clk_sys);
    chk(16'(n_conv - n0), 16'h0000);
    chk(16'(n_irq - i0), 16'h0000);
    idle <= 1'b0;
    wait_irq();
    wr(ADDR_CON1, 16'h0000);
    $display("test auto sequence finished");
    r = xs();
    // Channel 0 left out so the scan must find its own first channel
    m = (r[15:0] & 16'hfffe) | 16'h8000;
    wr(ADDR_SCAN, m);
    wr(ADDR_CON2, {r[18:16], 3'h1, 2'h0, 1'b0, 5'h03, 2'h0});
    wr(ADDR_CON1, 16'h80e4);
    wr(ADDR_CON1, 16'h80e6);
    wait_irq();
    for (int j = 0; j < 4; j++)
      rdc(ADDR_BUF_BASE + 6'(j), fmt(scan_ch(m, j), OUTPUT_FORMAT_INT));
    wr(ADDR_CON1, 16'h0000);
    $display("test scan finished");
    give_verdict();
  end
endmodule : sas_sequencer_test
